/* File: hdl/exec_slice_regs.svh */
/*
 * Register offsets, field positions, reset values and counter widths of the
 * execution slice. Included by bare name; defines only.
 */
`ifndef EXEC_SLICE_REGS_SVH
`define EXEC_SLICE_REGS_SVH

// ===========================================================================
// register byte offsets
`define OFF_CMD 10'h000
`define OFF_ACC 10'h004
`define OFF_STATUS 10'h008
`define OFF_PC 10'h00c
`define OFF_WATCH 10'h010
`define OFF_PUSH 10'h014
// file registers: 10'h200 + 4 * index, index 0..127
`define FILE_WIN_BIT 9

// ===========================================================================
// command word fields
`define CMD_LIT_LSB 0
`define CMD_FADDR_LSB 8
`define CMD_DEST_BIT 15
`define CMD_OP_LSB 16
`define CMD_WIDTH 20

// ===========================================================================
// status word fields
`define ST_CARRY 0
`define ST_NIB 1
`define ST_ZERO 2
`define ST_PWRDN_N 3
`define ST_EXPIRY_N 4
`define ST_HALTED 5
`define ST_BUSY 6
`define ST_SP_LSB 8

// ===========================================================================
// reset values and widths
`define PC_WIDTH 13
`define PC_RST 13'h0000
`define ACC_RST 8'h00
`define FILE_RST 8'h00
`define FLAGS_RST 5'h18
`define WATCH_PRE_WIDTH 8
`define WATCH_CNT_WIDTH 8

`endif

/* File: hdl/exec_slice_pkg.sv */
/*
 * Types of the execution slice: instruction codes and sequencer states.
 * Assumes exec_slice_regs.svh for the numeric constants.
 */
package exec_slice_pkg;

   // ========================================================================
   // instruction codes held in the command word
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_RETURN = 4'h1,
      OP_SLEEP = 4'h2,
      OP_LITERAL_MINUS_ACC = 4'h3,
      OP_ACC_XOR_LITERAL = 4'h4,
      OP_FILE_MINUS_ACC = 4'h5,
      OP_ACC_XOR_FILE = 4'h6,
      OP_NIBBLE_EXCHANGE = 4'h7,
      OP_WAKE = 4'h8
   } op_type;

   // ========================================================================
   // sequencer
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_RET_SECOND,
      ST_HALT
   } state_type;

endpackage : exec_slice_pkg

/* File: hdl/alu_if.sv */
/*
 * Operand and result bundle between the core sequencer and the ALU.
 * Assumes exec_slice_pkg is compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

interface alu_if;
   import exec_slice_pkg::*;
   op_type op;
   logic [7:0] acc;
   logic [7:0] opnd;
   logic [7:0] result;
   logic carry;
   logic nib;
   logic zero;
   logic upd_c;
   logic upd_dc;
   logic upd_z;

   modport alu (input op, acc, opnd,
      output result, carry, nib, zero, upd_c, upd_dc, upd_z);
   modport core (output op, acc, opnd,
      input result, carry, nib, zero, upd_c, upd_dc, upd_z);
endinterface : alu_if

`default_nettype wire

/* File: hdl/sub_xor_swap_alu.sv */
/*
 * Combinational ALU: subtract, exclusive-OR and nibble exchange with flag
 * results and per-flag update enables.
 * Assumes the core supplies the operand already selected (literal or file).
 */
`timescale 1ns/100ps
`default_nettype none

module sub_xor_swap_alu
   import exec_slice_pkg::*;
(
   alu_if.alu bus
);

   logic [8:0] diff;
   logic [4:0] low_diff;

   // operand minus accumulator, two's complement; top bit is no-borrow
   assign diff = {1'b0, bus.opnd} + {1'b0, ~bus.acc} + 9'h001;
   assign low_diff = {1'b0, bus.opnd[3:0]} + {1'b0, ~bus.acc[3:0]} + 5'h01;

   always_comb begin
      bus.result = bus.acc;
      bus.upd_c = 1'b0;
      bus.upd_dc = 1'b0;
      bus.upd_z = 1'b0;
      unique case (bus.op)
         OP_LITERAL_MINUS_ACC, OP_FILE_MINUS_ACC: begin
            bus.result = diff[7:0];
            bus.upd_c = 1'b1;
            bus.upd_dc = 1'b1;
            bus.upd_z = 1'b1;
         end
         OP_ACC_XOR_LITERAL, OP_ACC_XOR_FILE: begin
            bus.result = bus.acc ^ bus.opnd;
            bus.upd_z = 1'b1;
         end
         OP_NIBBLE_EXCHANGE: begin
            bus.result = {bus.opnd[3:0], bus.opnd[7:4]};
         end
         default: begin
            bus.result = bus.acc;
         end
      endcase
   end

   assign bus.carry = diff[8];
   assign bus.nib = low_diff[4];
   assign bus.zero = (bus.result == 8'h00);

endmodule : sub_xor_swap_alu

`default_nettype wire

/* File: hdl/exec_slice_core.sv */
/*
 * Execution slice of an 8-bit core: subroutine return, halt with watchdog
 * and power flags, subtract, exclusive-OR and nibble exchange, driven by
 * commands written over a classic Wishbone slave.
 * Assumes a single clock; the master is on the same clock, so bus inputs
 * are not synchronised.
 */
`timescale 1ns/100ps
`default_nettype none

`include "exec_slice_regs.svh"

// Overview of operation
// - return loads program counter from stack top, takes two cycles
// - return pops the stack; the removed entry gives the counter
// - halt clears the watchdog counter and its prescaler
// - halt clears power-down flag, sets expiry flag, others unchanged
// - after halt nothing executes until a wake-up
// - literal minus accumulator into accumulator, carry, nibble and zero
// - accumulator xor literal into accumulator, zero flag only
// - file minus accumulator, carry, nibble and zero, index 0 to 127
// - accumulator xor file, zero flag only
// - nibble exchange swaps file halves, flags untouched
// - for file ops, destination bit 0 selects accumulator, 1 the file register
module exec_slice_core
   import exec_slice_pkg::*;
#(
   parameter int STACK_DEPTH = 8,
   parameter int WATCH_PRE_W = `WATCH_PRE_WIDTH,
   parameter int WATCH_CNT_W = `WATCH_CNT_WIDTH
)(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic HALTED,
   output logic BUSY
);

   localparam int SP_W = $clog2(STACK_DEPTH);

   // =========================================================================
   // state
   logic ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   state_type state_q;
   state_type state_d;
   logic halted_q;
   logic busy_q;
   logic [`CMD_WIDTH-1:0] cmd_q;
   logic [7:0] acc_q;
   logic [`PC_WIDTH-1:0] pc_q;
   logic [`PC_WIDTH-1:0] stack_q [STACK_DEPTH];
   logic [SP_W-1:0] sp_q;
   logic [7:0] file_q [128];
   logic carry_q;
   logic nib_q;
   logic zero_q;
   logic pwrdn_n_q;
   logic expiry_n_q;
   logic [WATCH_PRE_W-1:0] watch_pre_q;
   logic [WATCH_CNT_W-1:0] watch_cnt_q;

   // =========================================================================
   // bus decode
   logic req;
   logic wr_commit;
   logic [9:0] word_adr;
   logic in_file_win;
   logic [6:0] file_idx;
   logic wr_cmd;
   logic wr_acc;
   logic wr_status;
   logic wr_pc;
   logic wr_push;
   logic wr_file;
   op_type wr_op;
   logic start_cmd;
   logic wake_cmd;

   assign req = WB_CYC_I & WB_STB_I;
   // writes land on the edge where ack is seen high
   assign wr_commit = req & WB_WE_I & ack_q;
   assign word_adr = {WB_ADR_I[9:2], 2'b00};
   assign in_file_win = WB_ADR_I[`FILE_WIN_BIT];
   assign file_idx = WB_ADR_I[8:2];

   assign wr_cmd = wr_commit & ~in_file_win & (word_adr == `OFF_CMD)
      & (&WB_SEL_I[2:0]);
   assign wr_acc = wr_commit & ~in_file_win & (word_adr == `OFF_ACC)
      & WB_SEL_I[0];
   assign wr_status = wr_commit & ~in_file_win
      & (word_adr == `OFF_STATUS) & WB_SEL_I[0];
   assign wr_pc = wr_commit & ~in_file_win & (word_adr == `OFF_PC);
   assign wr_push = wr_commit & ~in_file_win & (word_adr == `OFF_PUSH)
      & (&WB_SEL_I[1:0]);
   assign wr_file = wr_commit & in_file_win & WB_SEL_I[0];

   assign wr_op = op_type'(WB_DAT_I[`CMD_OP_LSB +: 4]);
   assign start_cmd = wr_cmd & (state_q == ST_IDLE) & (wr_op != OP_WAKE);
   assign wake_cmd = wr_cmd & (state_q == ST_HALT) & (wr_op == OP_WAKE);

   // =========================================================================
   // command fields and ALU hookup
   alu_if alu_bus ();

   op_type op;
   logic [7:0] lit;
   logic [6:0] faddr;
   logic dest_file;
   logic file_op;
   logic exec_now;
   logic watch_over;
   logic [SP_W-1:0] sp_pop;

   assign op = op_type'(cmd_q[`CMD_OP_LSB +: 4]);
   assign lit = cmd_q[`CMD_LIT_LSB +: 8];
   assign faddr = cmd_q[`CMD_FADDR_LSB +: 7];
   assign dest_file = cmd_q[`CMD_DEST_BIT];
   assign file_op = (op == OP_FILE_MINUS_ACC) | (op == OP_ACC_XOR_FILE)
      | (op == OP_NIBBLE_EXCHANGE);
   assign exec_now = (state_q == ST_EXEC);
   assign watch_over = (&watch_pre_q) & (&watch_cnt_q);
   assign sp_pop = sp_q - SP_W'(1);

   assign alu_bus.op = op;
   assign alu_bus.acc = acc_q;
   assign alu_bus.opnd = file_op ? file_q[faddr] : lit;

   sub_xor_swap_alu u_alu (
      .bus (alu_bus.alu)
   );

   // =========================================================================
   // wishbone handshake and read data
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (in_file_win) begin
         rdata_d[7:0] = file_q[file_idx];
      end else begin
         unique case (word_adr)
            `OFF_CMD: rdata_d[`CMD_WIDTH-1:0] = cmd_q;
            `OFF_ACC: rdata_d[7:0] = acc_q;
            `OFF_STATUS: begin
               rdata_d[`ST_CARRY] = carry_q;
               rdata_d[`ST_NIB] = nib_q;
               rdata_d[`ST_ZERO] = zero_q;
               rdata_d[`ST_PWRDN_N] = pwrdn_n_q;
               rdata_d[`ST_EXPIRY_N] = expiry_n_q;
               rdata_d[`ST_HALTED] = halted_q;
               rdata_d[`ST_BUSY] = busy_q;
               rdata_d[`ST_SP_LSB +: SP_W] = sp_q;
            end
            `OFF_PC: rdata_d[`PC_WIDTH-1:0] = pc_q;
            `OFF_WATCH: begin
               rdata_d[WATCH_PRE_W-1:0] = watch_pre_q;
               rdata_d[16 +: WATCH_CNT_W] = watch_cnt_q;
            end
            `OFF_PUSH: rdata_d[`PC_WIDTH-1:0] = stack_q[sp_pop];
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= (req & ~ack_q & ~WB_WE_I) ? rdata_d : 32'h0000_0000;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdata_q;

   // =========================================================================
   // sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start_cmd) begin
               state_d = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (op == OP_RETURN) begin
               state_d = ST_RET_SECOND;
            end else if (op == OP_SLEEP) begin
               state_d = ST_HALT;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_RET_SECOND: begin
            state_d = ST_IDLE;
         end
         ST_HALT: begin
            if (wake_cmd | watch_over) begin
               state_d = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         halted_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         halted_q <= (state_d == ST_HALT);
         busy_q <= (state_d == ST_EXEC) | (state_d == ST_RET_SECOND);
      end
   end

   assign HALTED = halted_q;
   assign BUSY = busy_q;

   // =========================================================================
   // command latch: only taken while idle, so a halted core runs nothing
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         cmd_q <= '0;
      end else if (start_cmd) begin
         cmd_q <= WB_DAT_I[`CMD_WIDTH-1:0];
      end
   end

   // =========================================================================
   // accumulator
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_q <= `ACC_RST;
      end else if (exec_now) begin
         unique case (op)
            OP_LITERAL_MINUS_ACC, OP_ACC_XOR_LITERAL: begin
               acc_q <= alu_bus.result;
            end
            OP_FILE_MINUS_ACC, OP_ACC_XOR_FILE, OP_NIBBLE_EXCHANGE: begin
               if (!dest_file) begin
                  acc_q <= alu_bus.result;
               end
            end
            default: begin
               acc_q <= acc_q;
            end
         endcase
      end else if (wr_acc) begin
         acc_q <= WB_DAT_I[7:0];
      end
   end

   // =========================================================================
   // file registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < 128; i++) begin
            file_q[i] <= `FILE_RST;
         end
      end else if (exec_now & file_op & dest_file) begin
         file_q[faddr] <= alu_bus.result;
      end else if (wr_file) begin
         file_q[file_idx] <= WB_DAT_I[7:0];
      end
   end

   // =========================================================================
   // status flags; hardware updates win over a software write
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         {expiry_n_q, pwrdn_n_q, zero_q, nib_q, carry_q} <= `FLAGS_RST;
      end else begin
         if (exec_now & (op == OP_SLEEP)) begin
            pwrdn_n_q <= 1'b0;
            expiry_n_q <= 1'b1;
         end else if (watch_over) begin
            expiry_n_q <= 1'b0;
         end else if (wr_status) begin
            pwrdn_n_q <= WB_DAT_I[`ST_PWRDN_N];
            expiry_n_q <= WB_DAT_I[`ST_EXPIRY_N];
         end
         if (exec_now & (alu_bus.upd_c | alu_bus.upd_z)) begin
            if (alu_bus.upd_c) begin
               carry_q <= alu_bus.carry;
            end
            if (alu_bus.upd_dc) begin
               nib_q <= alu_bus.nib;
            end
            if (alu_bus.upd_z) begin
               zero_q <= alu_bus.zero;
            end
         end else if (wr_status) begin
            carry_q <= WB_DAT_I[`ST_CARRY];
            nib_q <= WB_DAT_I[`ST_NIB];
            zero_q <= WB_DAT_I[`ST_ZERO];
         end
      end
   end

   // =========================================================================
   // program counter
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pc_q <= `PC_RST;
      end else if (exec_now) begin
         if (op == OP_RETURN) begin
            pc_q <= stack_q[sp_pop];
         end else begin
            pc_q <= pc_q + `PC_WIDTH'(1);
         end
      end else if (wr_pc) begin
         if (WB_SEL_I[0]) begin
            pc_q[7:0] <= WB_DAT_I[7:0];
         end
         if (WB_SEL_I[1]) begin
            pc_q[`PC_WIDTH-1:8] <= WB_DAT_I[`PC_WIDTH-1:8];
         end
      end
   end

   // =========================================================================
   // hardware stack, circular; a push in the first cycle of a return is dropped
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sp_q <= '0;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_q[i] <= `PC_RST;
         end
      end else if (exec_now & (op == OP_RETURN)) begin
         sp_q <= sp_pop;
      end else if (wr_push) begin
         stack_q[sp_q] <= WB_DAT_I[`PC_WIDTH-1:0];
         sp_q <= sp_q + SP_W'(1);
      end
   end

   // =========================================================================
   // watchdog: prescaler feeds the counter, runs also while halted
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         watch_pre_q <= '0;
         watch_cnt_q <= '0;
      end else if (exec_now & (op == OP_SLEEP)) begin
         watch_pre_q <= '0;
         watch_cnt_q <= '0;
      end else begin
         watch_pre_q <= watch_pre_q + WATCH_PRE_W'(1);
         if (&watch_pre_q) begin
            watch_cnt_q <= watch_cnt_q + WATCH_CNT_W'(1);
         end
      end
   end

endmodule : exec_slice_core

`default_nettype wire

/* File: verif/exec_slice_core_checker.sv */
/*
 * Concurrent checks on the ports of exec_slice_core.
 * Assumes one clock domain; the bind statement follows the module.
 */
`timescale 1ns/100ps
`default_nettype none

module exec_slice_core_checker
   import exec_slice_pkg::*;
#(
   parameter int STACK_DEPTH = 8,
   parameter int WATCH_PRE_W = 8,
   parameter int WATCH_CNT_W = 8
)(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic HALTED,
   input wire logic BUSY
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // =====================================================================
   // request decode
   logic req;
   logic cmd_wr;
   logic cmd_ok;
   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign cmd_wr = req && WB_WE_I && WB_ADR_I[9:2] == 8'h00
      && WB_SEL_I[2:0] == 3'b111;
   assign cmd_ok = cmd_wr && !BUSY && !HALTED;

   // command accepted by an idle core, then acknowledged
   sequence taken_s(ok);
      cmd_ok && ok ##1 WB_ACK_O && !BUSY;
   endsequence

   sequence wake_s;
      HALTED && cmd_wr && WB_DAT_I[19:16] == OP_WAKE ##1 WB_ACK_O;
   endsequence

   // =====================================================================
   // bus
   ack_single_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   ack_next_cycle_a: assert property (req |=> WB_ACK_O)
      else $error("request not acknowledged in the next cycle");
   ack_has_request_a: assert property (
      WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without a request");
   read_data_quiet_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data not zero outside ack");

   // =====================================================================
   // instruction timing
   return_two_cycles_a: assert property (
      taken_s(WB_DAT_I[19:16] == OP_RETURN) |=> BUSY ##1 BUSY ##1 !BUSY)
      else $error("return did not take two cycles");
   single_cycle_op_a: assert property (
      taken_s(WB_DAT_I[19:16] inside {[4'h3:4'h7]}) |=> BUSY ##1 !BUSY)
      else $error("arithmetic op did not take one cycle");
   halt_after_sleep_a: assert property (
      taken_s(WB_DAT_I[19:16] == OP_SLEEP) |=> BUSY ##1 (HALTED && !BUSY))
      else $error("sleep did not halt the core");
   halted_no_exec_a: assert property (HALTED |-> !BUSY)
      else $error("instruction executing while halted");
   halt_ignores_cmd_a: assert property (
      HALTED && cmd_wr && WB_DAT_I[19:16] != OP_WAKE
      |=> HALTED ##1 HALTED ##1 HALTED)
      else $error("command left the halted state");
   wake_leaves_halt_a: assert property (wake_s |=> ##[0:2] !HALTED)
      else $error("wake did not leave the halted state");
endmodule : exec_slice_core_checker

bind exec_slice_core exec_slice_core_checker #(.STACK_DEPTH(STACK_DEPTH),
   .WATCH_PRE_W(WATCH_PRE_W), .WATCH_CNT_W(WATCH_CNT_W)) chk_i (.CLK(CLK),
   .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
   .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .HALTED(HALTED), .BUSY(BUSY));

`default_nettype wire

/* File: verif/sleep_subtract_xor_swap_ops_test.sv */
/*
 * Self-checking bench for exec_slice_core: bus, return, arithmetic ops,
 * halt and wake.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/100ps
`default_nettype none

`include "exec_slice_regs.svh"

module sleep_subtract_xor_swap_ops_test
   import exec_slice_pkg::*;
;
   logic clk, rst_n, cyc, stb, we, ack, halted, busy;
   logic [9:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r;
   int errors, n_checks, cycles;
   integer seed;

   exec_slice_core exec_slice_core_i (.CLK(clk), .RST_N(rst_n),
      .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
      .HALTED(halted), .BUSY(busy));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // =====================================================================
   // reporting
   task print_verdict;
      $display("checks %0d, errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask : chk

   // =====================================================================
   // bus cycles
   task automatic bus(input logic w, input logic [9:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hf;
      do @(posedge clk); while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [9:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic cmd(input logic [3:0] op, input logic [7:0] lit,
      input logic [6:0] fi, input logic d);
      wr(`OFF_CMD, {12'h000, op, d, fi, lit});
      repeat (2) @(posedge clk);
   endtask : cmd

   // expected {zero, nibble carry, carry, result}; a is literal or file
   function automatic logic [10:0] alu(input logic [3:0] op,
      input logic [7:0] a, input logic [7:0] w, input logic [2:0] fl);
      logic [7:0] r;
      logic [2:0] f;
      f = fl;
      r = a - w;
      if (op == OP_ACC_XOR_LITERAL || op == OP_ACC_XOR_FILE) r = a ^ w;
      if (op == OP_NIBBLE_EXCHANGE) r = {a[3:0], a[7:4]};
      if (op == OP_LITERAL_MINUS_ACC || op == OP_FILE_MINUS_ACC)
         f[1:0] = {a[3:0] >= w[3:0], a >= w};
      if (op != OP_NIBBLE_EXCHANGE) f[2] = (r == 8'h00);
      return {f, r};
   endfunction : alu

   // =====================================================================
   // main sequence
   initial begin
      logic [31:0] q;
      logic [7:0] acc, fv, lit;
      logic [6:0] fi;
      logic [3:0] op;
      logic d;
      logic [2:0] fl;
      logic [10:0] e;
      seed = 32'h331a;
      errors = 0;
      n_checks = 0;
      cycles = 0;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      sel = 4'h0;
      dat_w = 32'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(`OFF_STATUS, q);
      chk(q, 32'h18);
      rd(10'h100, q);
      chk(q, 32'h0);
      wr(`OFF_PUSH, 32'h0abc);
      wr(`OFF_PUSH, 32'h1234);
      cmd(OP_RETURN, 8'h00, 7'h00, 1'b0);
      rd(`OFF_PC, q);
      chk(q, 32'h1234);
      rd(`OFF_STATUS, q);
      chk(32'(q[10:8]), 32'h1);
      cmd(OP_RETURN, 8'h00, 7'h00, 1'b0);
      rd(`OFF_PC, q);
      chk(q, 32'h0abc);
      for (int k = 0; k < 48; k++) begin
         acc = 8'($random(seed));
         fv = 8'($random(seed));
         lit = 8'($random(seed));
         fi = 7'($random(seed));
         d = 1'($random(seed));
         fl = 3'($random(seed));
         op = 4'(3 + $unsigned($random(seed)) % 5);
         if (k < 5) begin
            op = 4'h3 + 4'(k);
            acc = 8'h5a;
            fv = 8'h5a;
            lit = 8'h5a;
            fi = 7'h7f;
         end
         wr(`OFF_ACC, {24'h0, acc});
         wr({1'b1, fi, 2'b00}, {24'h0, fv});
         wr(`OFF_STATUS, {27'h0, 2'b11, fl});
         cmd(op, lit, fi, d);
         e = alu(op, (op < 4'h5) ? lit : fv, acc, fl);
         rd(`OFF_ACC, q);
         chk(q, {24'h0, (op < 4'h5 || !d) ? e[7:0] : acc});
         rd({1'b1, fi, 2'b00}, q);
         chk(q, {24'h0, (op > 4'h4 && d) ? e[7:0] : fv});
         rd(`OFF_STATUS, q);
         chk(32'(q[4:0]), {27'h0, 2'b11, e[10:8]});
      end
      wr(`OFF_ACC, 32'h3c);
      wr(`OFF_STATUS, 32'h0f);
      cmd(OP_SLEEP, 8'h00, 7'h00, 1'b0);
      chk(32'(halted), 32'h1);
      rd(`OFF_STATUS, q);
      chk(32'(q[5:0]), 32'h37);
      rd(`OFF_WATCH, q);
      chk(32'(q[23:16]), 32'h0);
      chk(32'(q[7:0] < 8'h20), 32'h1);
      cmd(OP_ACC_XOR_LITERAL, 8'hff, 7'h00, 1'b0);
      rd(`OFF_ACC, q);
      chk(q, 32'h3c);
      cmd(OP_WAKE, 8'h00, 7'h00, 1'b0);
      chk(32'(halted), 32'h0);
      cmd(OP_ACC_XOR_LITERAL, 8'hff, 7'h00, 1'b0);
      rd(`OFF_ACC, q);
      chk(q, 32'hc3);
      // two returns, 48 ops, sleep, xor and a no-op have moved the counter
      cmd(OP_NOP, 8'h00, 7'h00, 1'b0);
      rd(`OFF_PC, q);
      chk(q, 32'h0aef);
      rd(`OFF_ACC, q);
      chk(q, 32'hc3);
      print_verdict();
   end
endmodule : sleep_subtract_xor_swap_ops_test

`default_nettype wire
